// ### src/adc_cfg_consts.vh
// Constants for the converter configuration register bank
`ifndef ADC_CFG_CONSTS_VH
`define ADC_CFG_CONSTS_VH
// Register addresses (7-bit, the eighth bit is the read flag)
`define ADDR_IFACE_FILTER 7'h00
`define ADDR_CORR_FORMAT 7'h01
`define ADDR_OVR_THRESH 7'h02
`define ADDR_CHA_ACORR 7'h03
`define ADDR_SYNC_LOW 7'h0E
`define ADDR_SYNC_REF 7'h0F
`define ADDR_CHB_ACORR 7'h1A
`define ADDR_DIE_TEMP 7'h2B
`define ADDR_SW_RESET 7'h2C
`define ADDR_SLEEP 7'h37
`define ADDR_BIAS_SYNC 7'h38
`define ADDR_DRIVER 7'h3A
`define ADDR_BUS_A_EN 7'h66
`define ADDR_BUS_B_EN 7'h67
// Memory slot indices (dense array of writable words)
`define SLOT_IFACE_FILTER 4'h0
`define SLOT_CORR_FORMAT 4'h1
`define SLOT_OVR_THRESH 4'h2
`define SLOT_CHA_ACORR 4'h3
`define SLOT_SYNC_LOW 4'h4
`define SLOT_SYNC_REF 4'h5
`define SLOT_CHB_ACORR 4'h6
`define SLOT_SLEEP 4'h7
`define SLOT_BIAS_SYNC 4'h8
`define SLOT_DRIVER 4'h9
`define SLOT_BUS_A_EN 4'hA
`define SLOT_BUS_B_EN 4'hB
`define SLOT_COUNT 12
`define SLOT_NONE 4'hF
// Field positions
`define BIT_FOUR_WIRE 15
`define BIT_DECIM_EN 14
`define BIT_CHA_BAND 12
`define BIT_CHB_BAND 9
`define BIT_CHA_FIX 15
`define BIT_CHB_FIX 9
`define BIT_OFFSET_BIN 3
`define BIT_PERF_FIRST 1
`define BIT_OVR_HI 10
`define BIT_OVR_LO 7
// Reset values of writable words
`define RST_IFACE_FILTER 16'h0000
`define RST_CORR_FORMAT 16'h0000
`define RST_OVR_THRESH 16'h0780
`define RST_ACORR 16'h4B18
`define RST_SYNC_LOW 16'hAAA8
`define RST_SYNC_REF 16'hA000
`define RST_OTHER 16'h0000
`define RST_ZERO 16'h0000
`define RST_OVR_FIELD 4'hF
// Frame layout
`define ADDR_BITS 8
`define FRAME_BITS 24
`define CNT_ZERO 5'h00
`define CNT_ONE 5'h01
`endif

// ### src/cfg_word_mem.v
// Small register memory holding the writable configuration words
`default_nettype none
module cfg_word_mem (
  input wire sys_clk,
  input wire clkEn,
  input wire wrEn,
  input wire [3:0] wrSlot,
  input wire [15:0] wrData,
  input wire [3:0] rdSlot,
  output reg [15:0] rdData
);
  reg [15:0] mem [0:15];

  // ----------------------------------------
  // Write port and registered read port
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (clkEn) begin
      if (wrEn) begin
        mem[wrSlot] <= wrData;
      end
      rdData <= mem[rdSlot];
    end
  end
endmodule // cfg_word_mem
`default_nettype wire

// ### src/adc_serial_config_registers.v
// Serial-programmed configuration register bank of a dual converter
// Operation
// - D15 of word 0 selects four-wire readback
// - D14 of word 0 enables 2x decimation
// - D12 word 0 picks channel A band when D14 is set
// - D9 word 0 picks channel B band when D14 is set
// - D15 of word 1 enables A correction
// - D9 of word 1 enables B correction
// - One write updates all fields of its word together
// - Frame: 8-bit address then 16-bit data
// - First edge latches read flag; select ends
// - Writing 0x2C restores defaults, self clears
`include "adc_cfg_consts.vh"
`default_nettype none
module adc_serial_config_registers (
  input wire sys_clk,
  input wire rst,
  input wire clkEn,
  input wire serial_select_n,
  input wire serialClk,
  input wire serialDataIn,
  output reg serialDataOut,
  output reg serialDataOe,
  output reg serial_readback_pin,
  input wire [8:0] dieTemp,
  output reg fourWireOn,
  output reg decimOn,
  output reg chan_a_band_select,
  output reg chan_b_band_select,
  output reg chan_a_mismatch_fix_on,
  output reg chan_b_mismatch_fix_on,
  output reg offsetBinaryOn,
  output reg perf_mode_first,
  output reg [3:0] ovrThresh
);
  // States, one-hot
  localparam [3:0] ST_INIT = 4'h1;
  localparam [3:0] ST_IDLE = 4'h2;
  localparam [3:0] ST_SHIFT = 4'h4;
  localparam [3:0] ST_DONE = 4'h8;

  // Address to memory slot; 4'hF marks no storage
  function [3:0] slotOf;
    input [6:0] a;
    begin
      case (a)
        `ADDR_IFACE_FILTER: slotOf = `SLOT_IFACE_FILTER;
        `ADDR_CORR_FORMAT: slotOf = `SLOT_CORR_FORMAT;
        `ADDR_OVR_THRESH: slotOf = `SLOT_OVR_THRESH;
        `ADDR_CHA_ACORR: slotOf = `SLOT_CHA_ACORR;
        `ADDR_SYNC_LOW: slotOf = `SLOT_SYNC_LOW;
        `ADDR_SYNC_REF: slotOf = `SLOT_SYNC_REF;
        `ADDR_CHB_ACORR: slotOf = `SLOT_CHB_ACORR;
        `ADDR_SLEEP: slotOf = `SLOT_SLEEP;
        `ADDR_BIAS_SYNC: slotOf = `SLOT_BIAS_SYNC;
        `ADDR_DRIVER: slotOf = `SLOT_DRIVER;
        `ADDR_BUS_A_EN: slotOf = `SLOT_BUS_A_EN;
        `ADDR_BUS_B_EN: slotOf = `SLOT_BUS_B_EN;
        default: slotOf = `SLOT_NONE;
      endcase
    end
  endfunction

  // Default word of each slot
  function [15:0] defaultOf;
    input [3:0] s;
    begin
      case (s)
        `SLOT_OVR_THRESH: defaultOf = `RST_OVR_THRESH;
        `SLOT_CHA_ACORR: defaultOf = `RST_ACORR;
        `SLOT_CHB_ACORR: defaultOf = `RST_ACORR;
        `SLOT_SYNC_LOW: defaultOf = `RST_SYNC_LOW;
        `SLOT_SYNC_REF: defaultOf = `RST_SYNC_REF;
        default: defaultOf = `RST_OTHER;
      endcase
    end
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  reg selMeta_reg, selSync_reg, clkMeta_reg, clkSync_reg, clkPrev_reg;
  reg dinMeta_reg, dinSync_reg;
  always @(posedge sys_clk) begin
    if (rst) begin
      selMeta_reg <= 1'b1;
      selSync_reg <= 1'b1;
      clkMeta_reg <= 1'b0;
      clkSync_reg <= 1'b0;
      clkPrev_reg <= 1'b0;
      dinMeta_reg <= 1'b0;
      dinSync_reg <= 1'b0;
    end else if (clkEn) begin
      selMeta_reg <= serial_select_n;
      selSync_reg <= selMeta_reg;
      clkMeta_reg <= serialClk;
      clkSync_reg <= clkMeta_reg;
      clkPrev_reg <= clkSync_reg;
      dinMeta_reg <= serialDataIn;
      dinSync_reg <= dinMeta_reg;
    end
  end
  wire sclkRise = clkSync_reg & ~clkPrev_reg;
  wire sclkFall = ~clkSync_reg & clkPrev_reg;
  wire selActive = ~selSync_reg;

  // ----------------------------------------
  // Frame engine
  // ----------------------------------------
  reg [3:0] state_reg, state_next;
  reg [4:0] bitCnt_reg;
  reg [7:0] addr_reg;
  reg [15:0] data_reg;
  reg [15:0] shOut_reg;
  reg [3:0] initSlot_reg;
  reg rdArm_reg, rdLoad_reg;
  reg memWe;
  reg [3:0] memSlot;
  reg [15:0] memData;
  wire [15:0] memRd;
  wire isRead = addr_reg[`ADDR_BITS-1];
  wire [3:0] curSlot = slotOf(addr_reg[6:0]);
  wire [15:0] newData = {data_reg[14:0], dinSync_reg};
  wire wordDone = sclkRise && (bitCnt_reg == `FRAME_BITS - 1);
  wire addrDone = sclkRise && (bitCnt_reg == `ADDR_BITS - 1);

  // Next state
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_INIT:
        if (initSlot_reg == `SLOT_COUNT - 1) state_next = ST_IDLE;
      ST_IDLE:
        if (selActive) state_next = ST_SHIFT;
      ST_SHIFT:
        if (!selActive) state_next = ST_IDLE;
        else if (wordDone) state_next = ST_DONE;
      ST_DONE:
        if (!selActive) state_next = ST_IDLE;
      default: state_next = ST_INIT;
    endcase
  end

  // Memory write steering: defaults sweep, or a completed write
  always @* begin
    memWe = 1'b0;
    memSlot = curSlot;
    memData = newData;
    if (state_reg == ST_INIT) begin
      memWe = 1'b1;
      memSlot = initSlot_reg;
      memData = defaultOf(initSlot_reg);
    end else if (state_reg == ST_SHIFT && wordDone && !isRead &&
                 curSlot != `SLOT_NONE) begin
      memWe = 1'b1;
    end
  end

  // Software reset: a write to the reset word restarts the sweep
  wire swReset = state_reg == ST_SHIFT && wordDone && !isRead &&
                 addr_reg[6:0] == `ADDR_SW_RESET;

  // Sequencing, shifting and readback
  always @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= ST_INIT;
      bitCnt_reg <= `CNT_ZERO;
      addr_reg <= 8'h00;
      data_reg <= `RST_ZERO;
      shOut_reg <= `RST_ZERO;
      initSlot_reg <= 4'h0;
      rdArm_reg <= 1'b0;
      rdLoad_reg <= 1'b0;
    end else if (clkEn) begin
      state_reg <= swReset ? ST_INIT : state_next;
      // Read port lags the address register, so the load waits two edges
      rdArm_reg <= addrDone && state_reg == ST_SHIFT;
      rdLoad_reg <= rdArm_reg;
      if (state_reg == ST_INIT) begin
        initSlot_reg <= initSlot_reg + 4'h1;
      end else begin
        initSlot_reg <= 4'h0;
      end
      if (state_reg != ST_SHIFT) begin
        bitCnt_reg <= `CNT_ZERO;
        shOut_reg <= `RST_ZERO;
      end else if (sclkRise) begin
        bitCnt_reg <= bitCnt_reg + `CNT_ONE;
        if (bitCnt_reg < `ADDR_BITS) begin
          addr_reg <= {addr_reg[6:0], dinSync_reg};
        end else begin
          data_reg <= newData;
        end
      end
      // Load readback word once the memory has seen the full address;
      // an earlier load would catch the word of a half-shifted address
      if (state_reg == ST_SHIFT && rdLoad_reg && isRead) begin
        shOut_reg <= addr_reg[6:0] == `ADDR_DIE_TEMP ?
                     {7'h00, dieTemp} :
                     (curSlot == `SLOT_NONE ? `RST_ZERO : memRd);
      end else if (state_reg == ST_SHIFT && sclkFall &&
                   bitCnt_reg > `ADDR_BITS) begin
        shOut_reg <= {shOut_reg[14:0], 1'b0};
      end
    end
  end

  cfg_word_mem wordMem (
    .sys_clk(sys_clk),
    .clkEn(clkEn),
    .wrEn(memWe),
    .wrSlot(memSlot),
    .wrData(memData),
    .rdSlot(curSlot),
    .rdData(memRd)
  );

  // ----------------------------------------
  // Field decode and pin drive, all registered
  // ----------------------------------------
  reg [15:0] w0_reg, w1_reg, w2_reg;
  always @(posedge sys_clk) begin
    if (rst) begin
      w0_reg <= `RST_IFACE_FILTER;
      w1_reg <= `RST_CORR_FORMAT;
      w2_reg <= `RST_OVR_THRESH;
    end else if (clkEn && memWe) begin
      // Shadow copies keep control fields out of the memory read path
      if (memSlot == `SLOT_IFACE_FILTER) w0_reg <= memData;
      if (memSlot == `SLOT_CORR_FORMAT) w1_reg <= memData;
      if (memSlot == `SLOT_OVR_THRESH) w2_reg <= memData;
    end
  end

  // Readback drive: bidirectional pin in three-wire, own pin in four-wire
  wire readPhase = state_reg == ST_SHIFT && isRead &&
                   bitCnt_reg >= `ADDR_BITS && selActive;
  always @(posedge sys_clk) begin
    if (rst) begin
      serialDataOut <= 1'b0;
      serialDataOe <= 1'b0;
      serial_readback_pin <= 1'b0;
      fourWireOn <= 1'b0;
      decimOn <= 1'b0;
      chan_a_band_select <= 1'b0;
      chan_b_band_select <= 1'b0;
      chan_a_mismatch_fix_on <= 1'b0;
      chan_b_mismatch_fix_on <= 1'b0;
      offsetBinaryOn <= 1'b0;
      perf_mode_first <= 1'b0;
      ovrThresh <= `RST_OVR_FIELD;
    end else if (clkEn) begin
      fourWireOn <= w0_reg[`BIT_FOUR_WIRE];
      serialDataOe <= readPhase && !w0_reg[`BIT_FOUR_WIRE];
      serialDataOut <= readPhase && !w0_reg[`BIT_FOUR_WIRE] &&
                       shOut_reg[15];
      serial_readback_pin <= readPhase && w0_reg[`BIT_FOUR_WIRE] &&
                             shOut_reg[15];
      decimOn <= w0_reg[`BIT_DECIM_EN];
      // Band choice only matters with decimation on
      chan_a_band_select <= w0_reg[`BIT_DECIM_EN] &
                            w0_reg[`BIT_CHA_BAND];
      chan_b_band_select <= w0_reg[`BIT_DECIM_EN] &
                            w0_reg[`BIT_CHB_BAND];
      chan_a_mismatch_fix_on <= w1_reg[`BIT_CHA_FIX];
      chan_b_mismatch_fix_on <= w1_reg[`BIT_CHB_FIX];
      offsetBinaryOn <= w1_reg[`BIT_OFFSET_BIN];
      perf_mode_first <= w1_reg[`BIT_PERF_FIRST];
      ovrThresh <= w2_reg[`BIT_OVR_HI:`BIT_OVR_LO];
    end
  end
endmodule // adc_serial_config_registers
`default_nettype wire

// ### test/cfg_bank_chk.sv
// Port-level assertions for the configuration register bank
`default_nettype none
module cfg_chk (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic serial_select_n,
  input wire logic serialClk,
  input wire logic serialDataOe,
  input wire logic serial_readback_pin,
  input wire logic fourWireOn,
  input wire logic decimOn,
  input wire logic chan_a_band_select,
  input wire logic chan_b_band_select,
  input wire logic offsetBinaryOn,
  input wire logic [3:0] ovrThresh
);
  timeunit 1ns;
  timeprecision 100ps;
  logic sclkQ, selQ;
  logic [4:0] rises;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Rises since select fell; kept after select rises, as the
  // design sees select two flops late
  always_ff @(posedge sys_clk) begin
    sclkQ <= serialClk;
    selQ <= serial_select_n;
    if (rst || (selQ && !serial_select_n)) rises <= 5'h00;
    else if (serialClk && !sclkQ && rises != 5'h1F) rises <= rises + 5'h01;
  end
  sequence idle8;
    serial_select_n[*8];
  endsequence
  // Long idle: any write or reset sweep has long finished
  sequence settled;
    idle8 ##1 idle8;
  endsequence
  chk_band_a_gated: assert property (chan_a_band_select |-> decimOn)
    else $error("band A without decimation");
  chk_band_b_gated: assert property (chan_b_band_select |-> decimOn)
    else $error("band B without decimation");
  chk_sdio_three: assert property (serialDataOe |-> !fourWireOn)
    else $error("data pin driven in four-wire mode");
  chk_readback_quiet: assert property (
    !fourWireOn |-> !serial_readback_pin)
    else $error("readback pin active in three-wire mode");
  chk_oe_released: assert property (idle8 |-> !serialDataOe)
    else $error("data pin driven outside a frame");
  chk_cfg_held: assert property (settled |=>
    $stable({fourWireOn, decimOn, offsetBinaryOn, ovrThresh}))
    else $error("config changed while idle");
  chk_oe_after_addr: assert property (
    serialDataOe |-> rises >= 5'h08)
    else $error("data driven before address done");
  chk_rb_after_addr: assert property (
    serial_readback_pin |-> rises >= 5'h08)
    else $error("readback before address done");
endmodule // cfg_chk
bind adc_serial_config_registers cfg_chk chk (.sys_clk(sys_clk),
  .rst(rst), .serial_select_n(serial_select_n), .serialClk(serialClk),
  .serialDataOe(serialDataOe), .serial_readback_pin(serial_readback_pin),
  .fourWireOn(fourWireOn), .decimOn(decimOn),
  .chan_a_band_select(chan_a_band_select),
  .chan_b_band_select(chan_b_band_select),
  .offsetBinaryOn(offsetBinaryOn), .ovrThresh(ovrThresh));
`default_nettype wire

// ### test/serial_host.sv
// Serial host model that frames register accesses
`default_nettype none
module serial_host (
  input wire logic sys_clk,
  input wire logic sdioLine,
  input wire logic readbackPin,
  output logic selN,
  output logic sclk,
  output logic hostData,
  output logic [15:0] rdData,
  output logic rdValid
);
  timeunit 1ns;
  timeprecision 100ps;
  // Serial clock rests low between frames
  initial begin
    selN = 1'b1;
    sclk = 1'b0;
    hostData = 1'b0;
    rdData = 16'h0000;
    rdValid = 1'b0;
  end
  // Read flag, address, data, MSB first; len below 24 cuts it
  task automatic xfer(input logic rd, input logic [6:0] a,
      input logic [15:0] d, input logic fw, input int len);
    logic [23:0] f;
    f = {rd, a, d};
    @(negedge sys_clk);
    selN = 1'b0;
    repeat (4) @(negedge sys_clk);
    for (int i = 23; i >= 24 - len; i--) begin
      // Released during read data: toggle so no stale level
      hostData = (rd && i < 16) ? ~hostData : f[i];
      repeat (4) @(negedge sys_clk);
      sclk = 1'b1;
      if (rd && i < 16) rdData[i] = fw ? readbackPin : sdioLine;
      repeat (4) @(negedge sys_clk);
      sclk = 1'b0;
    end
    repeat (24) @(negedge sys_clk);
    selN = 1'b1;
    rdValid = rd && len == 24;
    @(negedge sys_clk);
    rdValid = 1'b0;
    repeat (20) @(negedge sys_clk);
  endtask
endmodule // serial_host
`default_nettype wire

// ### test/adc_serial_config_registers_bench.sv
// Bench for the serial configuration register bank
`default_nettype none
module adc_serial_config_registers_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk, rst, en, fw, selN, sclk, hData, rdV, oe, sOut, rb;
  logic fourW, decim, bandA, bandB, fixA, fixB, offBin, perf;
  logic [3:0] ovr;
  logic [8:0] temp;
  logic [15:0] rdD, w0, w1, w2;
  logic [15:0] expQ[$];
  logic [6:0] adr[8] = '{7'h00, 7'h02, 7'h03, 7'h0E, 7'h0F, 7'h1A,
    7'h2C, 7'h10};
  logic [15:0] dfl[8] = '{16'h0000, 16'h0780, 16'h4B18, 16'hAAA8,
    16'hA000, 16'h4B18, 16'h0000, 16'h0000};
  int n_fail = 0;
  int compares = 0;
  int seed = 83;
  wire sdio = oe ? sOut : hData; // Shared pin level
  adc_serial_config_registers DUT (.sys_clk(sys_clk), .rst(rst),
    .clkEn(en), .serial_select_n(selN), .serialClk(sclk),
    .serialDataIn(sdio), .serialDataOut(sOut), .serialDataOe(oe),
    .serial_readback_pin(rb), .dieTemp(temp), .fourWireOn(fourW),
    .decimOn(decim), .chan_a_band_select(bandA),
    .chan_b_band_select(bandB), .chan_a_mismatch_fix_on(fixA),
    .chan_b_mismatch_fix_on(fixB), .offsetBinaryOn(offBin),
    .perf_mode_first(perf), .ovrThresh(ovr));
  serial_host host (.sys_clk(sys_clk), .sdioLine(sdio), .readbackPin(rb),
    .selN(selN), .sclk(sclk), .hostData(hData), .rdData(rdD),
    .rdValid(rdV));
  task automatic note(input logic ok, input string m);
    compares++;
    if (!ok) begin
      n_fail++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic check_word(input logic [15:0] got, input logic [15:0] e);
    note(got === e, "read word");
  endtask
  task automatic check_cfg(input logic [11:0] e);
    note({fourW, decim, bandA, bandB, fixA, fixB, offBin, perf, ovr}
      === e, "config levels");
  endtask
  // Level outputs expected from the three control words
  function automatic logic [11:0] cfgOf(input logic [15:0] a, b, c);
    return {a[15], a[14], a[12] & a[14], a[9] & a[14], b[15], b[9],
      b[3], b[1], c[10:7]};
  endfunction
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    host.xfer(1'b0, a, d, fw, 24);
  endtask
  task automatic rd(input logic [6:0] a, input logic [15:0] e);
    expQ.push_back(e);
    host.xfer(1'b1, a, 16'h0000, fw, 24);
  endtask
  task automatic report_and_stop();
    if (n_fail == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // Hang guard
  initial begin
    #2000000;
    n_fail++;
    report_and_stop();
  end
  // Oldest noted read is matched when the host finishes a read
  always @(posedge sys_clk) begin
    if (rdV) check_word(rdD, expQ.pop_front());
  end
  initial begin
    rst = 1'b1;
    en = 1'b1;
    fw = 1'b0;
    temp = 9'($random(seed));
    repeat (6) @(negedge sys_clk);
    rst = 1'b0;
    repeat (20) @(negedge sys_clk);
    check_cfg(12'h00F);
    for (int i = 0; i < 8; i++) rd(adr[i], dfl[i]);
    wr(7'h2B, 16'hFFFF);
    rd(7'h2B, {7'h00, temp});
    // Only legal bits written, fixed bits kept
    for (int k = 0; k < 6; k++) begin
      w0 = 16'($random(seed)) & 16'h5200;
      w1 = 16'($random(seed)) & 16'h820A;
      w2 = 16'($random(seed)) & 16'h0780;
      wr(7'h00, w0);
      wr(7'h01, w1);
      wr(7'h02, w2);
      check_cfg(cfgOf(w0, w1, w2));
      rd(7'h00, w0);
      rd(7'h01, w1);
    end
    host.xfer(1'b0, 7'h01, ~w1, fw, 20);
    check_cfg(cfgOf(w0, w1, w2));
    // Enable low for a whole frame: the write must never land
    en = 1'b0;
    wr(7'h01, w1 ^ 16'h820A);
    en = 1'b1;
    check_cfg(cfgOf(w0, w1, w2));
    rd(7'h01, w1);
    w0 = w0 | 16'h8000;
    wr(7'h00, w0);
    fw = 1'b1;
    check_cfg(cfgOf(w0, w1, w2));
    rd(7'h01, w1);
    wr(7'h2C, 16'hD2F0);
    fw = 1'b0;
    check_cfg(12'h00F);
    rd(7'h2C, 16'h0000);
    rd(7'h01, 16'h0000);
    report_and_stop();
  end
endmodule // adc_serial_config_registers_bench
`default_nettype wire
